// ===== inc/ucp_params.svh
// Offsets, field positions, reset values and counts of the channel pair.
// Assumes a 4-bit word address and 16-bit data.
`ifndef UCP_PARAMS_SVH
`define UCP_PARAMS_SVH
`define UCP_AW 4
`define UCP_DW 16
`define UCP_DIV_W 7
`define UCP_OFS_CFG 4'h0
`define UCP_OFS_DIV 4'h1
`define UCP_OFS_INV 4'h2
`define UCP_OFS_FILT 4'h3
`define UCP_OFS_LEVEL 4'h4
`define UCP_OFS_GATE 4'h5
`define UCP_OFS_PDATA 4'h6
`define UCP_OFS_PDIR 4'h7
`define UCP_OFS_TXDATA 4'h8
`define UCP_OFS_RXDATA 4'h9
`define UCP_OFS_STS 4'hA
`define UCP_OFS_MASK 4'hB
`define UCP_OFS_START 4'hC
`define UCP_OFS_RXMODE 4'hD
`define UCP_CFG_TXE 15
`define UCP_CFG_RXE 14
`define UCP_CFG_EOC 10
`define UCP_CFG_DIR 7
`define UCP_DIV_LSB 9
`define UCP_TX_PIN 4
`define UCP_RX_PIN 5
`define UCP_START_RX 1
`define UCP_RXMODE_SRC 8
`define UCP_RXMODE_INV 6
`define UCP_RXD_PERR 12
`define UCP_RXD_FERR 13
`define UCP_STS_TX 0
`define UCP_STS_RX 1
`define UCP_STS_ERR 2
`define UCP_CFG_RST 16'h0017
`define UCP_DIV_RST 7'h00
`define UCP_PDATA_RST 8'h00
`define UCP_PDIR_RST 8'hFF
`define UCP_RXMODE_RST 2'h2
`endif

// ===== inc/ucp_pkg.sv
// Shared types: bus request, state enums and state records.
// Assumes ucp_params.svh is on the include path.
`include "ucp_params.svh"
package ucp_pkg;
    typedef struct packed {
        logic [`UCP_AW-1:0] addr;
        logic [`UCP_DW-1:0] wdata;
        logic we, re;
    } ucp_bus_t;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ucp_tx_st_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ucp_rx_st_t;
    typedef struct packed {
        logic [`UCP_DIV_W-1:0] cnt;
        logic tick;
    } ucp_baud_t;
    typedef struct packed {
        logic s1, s2, s3, lvl;
    } ucp_filt_t;
    typedef struct packed {
        logic [15:0] cfg;
        logic [`UCP_DIV_W-1:0] div;
        logic inv, filt, so, gate;
        logic [7:0] pdata, pdir;
        logic [1:0] rxmode;
        logic armed;
        logic [2:0] sts, mask;
        ucp_tx_st_t tx_st;
        logic [8:0] tx_sh;
        logic [3:0] tx_idx;
        logic tx_half;
        ucp_rx_st_t rx_st;
        logic [8:0] rx_sh;
        logic [3:0] rx_idx;
        logic rx_half, rx_par, rx_perr, rx_ferr, rx_prev;
        logic [10:0] rx_word;
        logic [15:0] rdata;
        logic irq, tx_o, tx_oe, rx_o, rx_oe;
    } ucp_core_t;
endpackage

// ===== rtl/ucp_baud_gen.sv
// Half-bit tick: one pulse every div_i+1 clocks while run_i is high.
// Assumes div_i steady in a frame; the count restarts when run_i drops.
`include "ucp_params.svh"
module ucp_baud_gen (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [`UCP_DIV_W-1:0] div_i,
    input wire logic run_i,
    output logic tick_o
);
    import ucp_pkg::*;
    ucp_baud_t q, d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run_i) begin
            d.cnt = '0;
        end else if (q.cnt == div_i) begin
            d.cnt = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick_o = q.tick;
endmodule

// ===== rtl/ucp_rx_filter.sv
// Receive pin synchroniser with an optional two-sample glitch filter.
// Assumes the pin is asynchronous; the line idles high, so the filtered level resets to 1.
module ucp_rx_filter (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic pin_i,
    input wire logic filt_en_i,
    output logic level_o
);
    import ucp_pkg::*;
    ucp_filt_t q, d;

    always_comb begin
        d = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (!filt_en_i) begin
            d.lvl = q.s2;
        end else if (q.s2 == q.s3) begin
            d.lvl = q.s2; // RULE_09
        end
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= 4'hF;
        end else begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
endmodule

// ===== rtl/ucp_top.sv
// Channel pair: transmit channel, receive channel and register file.
// Assumes a same-clock register master and an asynchronous receive peer.
// How it works
// RULE_01 - Transmit parity field: none, zero, even or odd parity bit.
// RULE_02 - Receive parity field: none, unchecked, even or odd check.
// RULE_03 - Order bit clear shifts MSB first, set LSB first.
// RULE_04 - Stop field gives zero, one or two stop bits; 11 prohibited.
// RULE_05 - Length field: 01 nine, 10 seven, 11 eight bits; 00 prohibited.
// RULE_06 - Divider divides operation clock by twice its value plus two.
// RULE_07 - Software divides by 156 for about 9600 bit/s.
// RULE_08 - Inversion bit set inverts every transmitted bit.
// RULE_09 - Filter bit switches the receive noise filter on or off.
// RULE_10 - Level bit sets the transmit line; software writes 1 first.
// RULE_11 - Gate clear stops shifter output; set lets it reach the pin.
// RULE_12 - Software sets receive pin direction to 1, driver off.
// RULE_13 - Software clears transmit pin direction, presets its latch to 1.
// RULE_14 - Enable bits pick none, receive, transmit, or both.
// RULE_15 - Software waits four clocks after receive enable before start.
// RULE_16 - Error-interrupt bit set reports reception errors; clear masks.
// RULE_17 - Reception starts on a valid pin edge, falling by default.
// RULE_18 - Bits sampled at centre; parity and framing errors kept.
// RULE_19 - Character stored, receive-complete raised after the stop bits.
`include "ucp_params.svh"
module ucp_top (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire ucp_pkg::ucp_bus_t bus_i,
    output logic [`UCP_DW-1:0] rdata_o,
    output logic irq_o,
    output logic serial_tx_pin_o,
    output logic serial_tx_pin_oe_o,
    input wire logic serial_rx_pin_i,
    output logic serial_rx_pin_o,
    output logic serial_rx_pin_oe_o
);
    import ucp_pkg::*;
    ucp_core_t q, d;
    logic tx_tick, rx_tick, rx_lvl;

    ucp_baud_gen u_tx_baud (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .div_i(q.div),
        .run_i(q.tx_st != TX_IDLE),
        .tick_o(tx_tick)
    );

    ucp_baud_gen u_rx_baud (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .div_i(q.div),
        .run_i(q.rx_st != RX_IDLE),
        .tick_o(rx_tick)
    );

    ucp_rx_filter u_rx_filter (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(serial_rx_pin_i),
        .filt_en_i(q.filt),
        .level_o(rx_lvl)
    );

    // A prohibited length code falls back to eight bits.
    function automatic logic [3:0] char_len(input logic [1:0] f);
        case (f)
            2'h1: char_len = 4'h9;
            2'h2: char_len = 4'h7;
            default: char_len = 4'h8;
        endcase
    endfunction

    function automatic logic [3:0] bit_pos(input logic [3:0] i, input logic [3:0] n,
                                           input logic lsb);
        bit_pos = lsb ? i : 4'(n - 4'h1 - i);
    endfunction

    always_comb begin
        logic [3:0] n;
        logic [8:0] msk;
        logic [1:0] par_m;
        logic [1:0] stops;
        logic lsb, b, txb, txb_v, done;
        logic [2:0] set, clr;
        d = q;
        n = char_len(q.cfg[1:0]); // RULE_05
        msk = 9'h1FF >> (4'h9 - n);
        par_m = q.cfg[9:8];
        stops = q.cfg[5:4];
        lsb = q.cfg[`UCP_CFG_DIR];
        b = rx_lvl ^ q.rxmode[0];
        txb = 1'b1;
        txb_v = 1'b0;
        done = 1'b0;
        set = 3'h0;
        clr = 3'h0;
        d.rdata = 16'h0000;
        d.rx_prev = b;

        if (bus_i.we) begin
            if (bus_i.addr == `UCP_OFS_CFG) begin
                d.cfg = bus_i.wdata;
            end else if (bus_i.addr == `UCP_OFS_DIV) begin
                d.div = bus_i.wdata[15:`UCP_DIV_LSB]; // RULE_06
            end else if (bus_i.addr == `UCP_OFS_INV) begin
                d.inv = bus_i.wdata[0];
            end else if (bus_i.addr == `UCP_OFS_FILT) begin
                d.filt = bus_i.wdata[0];
            end else if (bus_i.addr == `UCP_OFS_LEVEL) begin
                d.so = bus_i.wdata[0]; // RULE_10
            end else if (bus_i.addr == `UCP_OFS_GATE) begin
                d.gate = bus_i.wdata[0];
            end else if (bus_i.addr == `UCP_OFS_PDATA) begin
                d.pdata = bus_i.wdata[7:0];
            end else if (bus_i.addr == `UCP_OFS_PDIR) begin
                d.pdir = bus_i.wdata[7:0];
            end else if (bus_i.addr == `UCP_OFS_TXDATA) begin
                if (q.cfg[`UCP_CFG_TXE] && q.tx_st == TX_IDLE) begin
                    d.tx_sh = bus_i.wdata[8:0];
                    d.tx_st = TX_START;
                    d.tx_half = 1'b0;
                    txb = 1'b0;
                    txb_v = 1'b1;
                end
            end else if (bus_i.addr == `UCP_OFS_STS) begin
                clr = bus_i.wdata[2:0];
            end else if (bus_i.addr == `UCP_OFS_MASK) begin
                d.mask = bus_i.wdata[2:0];
            end else if (bus_i.addr == `UCP_OFS_START) begin
                if (bus_i.wdata[`UCP_START_RX]) begin
                    d.armed = 1'b1;
                end
            end else if (bus_i.addr == `UCP_OFS_RXMODE) begin
                d.rxmode = {bus_i.wdata[`UCP_RXMODE_SRC], bus_i.wdata[`UCP_RXMODE_INV]};
            end
        end

        if (tx_tick && q.tx_st != TX_IDLE) begin
            d.tx_half = ~q.tx_half;
            if (q.tx_half) begin
                txb_v = 1'b1;
                case (q.tx_st)
                    TX_START: begin
                        d.tx_st = TX_DATA;
                        d.tx_idx = 4'h0;
                        txb = q.tx_sh[bit_pos(4'h0, n, lsb)]; // RULE_03
                    end
                    TX_DATA: begin
                        if (q.tx_idx != n - 4'h1) begin
                            d.tx_idx = q.tx_idx + 4'h1;
                            txb = q.tx_sh[bit_pos(d.tx_idx, n, lsb)];
                        end else if (par_m != 2'h0) begin
                            d.tx_st = TX_PAR;
                            txb = par_m[1] & ((^(q.tx_sh & msk)) ^ par_m[0]); // RULE_01
                        end else if (stops != 2'h0) begin
                            d.tx_st = TX_STOP;
                            d.tx_idx = 4'h0;
                        end else begin
                            done = 1'b1;
                        end
                    end
                    TX_PAR: begin
                        if (stops != 2'h0) begin
                            d.tx_st = TX_STOP;
                            d.tx_idx = 4'h0;
                        end else begin
                            done = 1'b1;
                        end
                    end
                    default: begin
                        d.tx_idx = q.tx_idx + 4'h1;
                        if (d.tx_idx == {2'h0, stops}) begin
                            done = 1'b1; // RULE_04
                        end
                    end
                endcase
                if (done) begin
                    d.tx_st = TX_IDLE;
                    set[`UCP_STS_TX] = 1'b1;
                end
            end
        end
        if (!q.cfg[`UCP_CFG_TXE]) begin
            d.tx_st = TX_IDLE; // RULE_14
        end
        if (txb_v && q.gate) begin
            d.so = txb ^ q.inv; // RULE_08 RULE_11
        end

        if (!q.cfg[`UCP_CFG_RXE]) begin
            d.armed = 1'b0; // RULE_14
            d.rx_st = RX_IDLE;
        end else if (q.rx_st == RX_IDLE) begin
            if (q.armed && q.rxmode[1] && q.rx_prev && !b) begin
                d.rx_st = RX_START; // RULE_17
                d.rx_half = 1'b0;
                d.rx_par = 1'b0;
                d.rx_perr = 1'b0;
                d.rx_ferr = 1'b0;
                d.rx_sh = 9'h000;
            end
        end else if (rx_tick) begin
            d.rx_half = ~q.rx_half;
            if (!q.rx_half) begin
                done = 1'b0;
                case (q.rx_st) // RULE_18
                    RX_START: begin
                        d.rx_st = b ? RX_IDLE : RX_DATA;
                        d.rx_idx = 4'h0;
                    end
                    RX_DATA: begin
                        d.rx_sh[bit_pos(q.rx_idx, n, lsb)] = b; // RULE_03
                        d.rx_par = q.rx_par ^ b;
                        d.rx_idx = q.rx_idx + 4'h1;
                        if (q.rx_idx == n - 4'h1) begin
                            if (par_m != 2'h0) begin
                                d.rx_st = RX_PAR;
                            end else if (stops != 2'h0) begin
                                d.rx_st = RX_STOP;
                                d.rx_idx = 4'h0;
                            end else begin
                                done = 1'b1;
                            end
                        end
                    end
                    RX_PAR: begin
                        d.rx_perr = par_m[1] & (q.rx_par ^ b ^ par_m[0]); // RULE_02
                        d.rx_idx = 4'h0;
                        if (stops != 2'h0) begin
                            d.rx_st = RX_STOP;
                        end else begin
                            done = 1'b1;
                        end
                    end
                    default: begin
                        d.rx_ferr = q.rx_ferr | ~b;
                        d.rx_idx = q.rx_idx + 4'h1;
                        if (d.rx_idx == {2'h0, stops}) begin
                            done = 1'b1; // RULE_04
                        end
                    end
                endcase
                if (done) begin
                    d.rx_st = RX_IDLE;
                    d.rx_word = {d.rx_ferr, d.rx_perr, d.rx_sh}; // RULE_19
                    set[`UCP_STS_RX] = 1'b1;
                    set[`UCP_STS_ERR] = q.cfg[`UCP_CFG_EOC] & (d.rx_ferr | d.rx_perr); // RULE_16
                end
            end
        end

        // A hardware event in the clearing cycle survives the write-one-to-clear.
        d.sts = (q.sts & ~clr) | set;
        d.irq = |(d.sts & d.mask);

        if (bus_i.re) begin
            if (bus_i.addr == `UCP_OFS_CFG) begin
                d.rdata = q.cfg;
            end else if (bus_i.addr == `UCP_OFS_DIV) begin
                d.rdata = {q.div, 9'h000};
            end else if (bus_i.addr == `UCP_OFS_INV) begin
                d.rdata = 16'(q.inv);
            end else if (bus_i.addr == `UCP_OFS_FILT) begin
                d.rdata = 16'(q.filt);
            end else if (bus_i.addr == `UCP_OFS_LEVEL) begin
                d.rdata = 16'(q.so);
            end else if (bus_i.addr == `UCP_OFS_GATE) begin
                d.rdata = 16'(q.gate);
            end else if (bus_i.addr == `UCP_OFS_PDATA) begin
                d.rdata = {8'h00, q.pdata[7:6], rx_lvl, q.pdata[4:0]};
            end else if (bus_i.addr == `UCP_OFS_PDIR) begin
                d.rdata = {8'h00, q.pdir};
            end else if (bus_i.addr == `UCP_OFS_TXDATA) begin
                d.rdata = {14'h0000, q.rx_st != RX_IDLE, q.tx_st != TX_IDLE};
            end else if (bus_i.addr == `UCP_OFS_RXDATA) begin
                d.rdata = {2'h0, q.rx_word[10:9], 3'h0, q.rx_word[8:0]};
            end else if (bus_i.addr == `UCP_OFS_STS) begin
                d.rdata = 16'(q.sts);
            end else if (bus_i.addr == `UCP_OFS_MASK) begin
                d.rdata = 16'(q.mask);
            end else if (bus_i.addr == `UCP_OFS_START) begin
                d.rdata = {14'h0000, q.armed, 1'b0};
            end else if (bus_i.addr == `UCP_OFS_RXMODE) begin
                d.rdata = {7'h00, q.rxmode[1], 1'b0, q.rxmode[0], 6'h00};
            end
        end

        d.tx_o = d.pdata[`UCP_TX_PIN] & d.so; // RULE_13
        d.tx_oe = ~d.pdir[`UCP_TX_PIN]; // RULE_13
        d.rx_o = d.pdata[`UCP_RX_PIN];
        d.rx_oe = ~d.pdir[`UCP_RX_PIN]; // RULE_12
    end

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= '0;
            q.cfg <= `UCP_CFG_RST;
            q.div <= `UCP_DIV_RST;
            q.so <= 1'b1;
            q.pdata <= `UCP_PDATA_RST;
            q.pdir <= `UCP_PDIR_RST;
            q.rxmode <= `UCP_RXMODE_RST;
            q.rx_prev <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign irq_o = q.irq;
    assign serial_tx_pin_o = q.tx_o;
    assign serial_tx_pin_oe_o = q.tx_oe;
    assign serial_rx_pin_o = q.rx_o;
    assign serial_rx_pin_oe_o = q.rx_oe;
endmodule

// ===== tb/ucp_peer.sv
// Serial peer: drives the receive line, samples the transmit line.
// Assumes frames as bit vectors, first wire bit in bit 0.
module ucp_peer (
    input wire logic sys_clk_i,
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Idles high between frames, as a pulled-up wire would.
    initial line_o = 1'b1;
    task automatic send(input logic [15:0] f, input int n, input int bitc);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            line_o <= f[i];
            repeat (bitc - 1) @(posedge sys_clk_i);
        end
        @(posedge sys_clk_i);
        line_o <= 1'b1;
    endtask
    // Falling-edge sampling keeps clear of the launch edge.
    task automatic recv(input logic idle, input int n, input int bitc, output logic [15:0] f);
        int k;
        f = 16'h0000;
        k = 0;
        while (line_i !== idle && k < 3000) begin
            @(negedge sys_clk_i);
            k++;
        end
        while (line_i === idle && k < 3000) begin
            @(negedge sys_clk_i);
            k++;
        end
        repeat (bitc / 2) @(negedge sys_clk_i);
        for (int i = 0; i < n; i++) begin
            f[i] = line_i;
            repeat (bitc) @(negedge sys_clk_i);
        end
    endtask
endmodule

// ===== tb/ucp_tb_top.sv
// Self-checking bench of the channel pair with a serial peer.
// Assumes the package, peer and checker compile first.
`include "ucp_params.svh"
module ucp_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import ucp_pkg::*;
    localparam logic [3:0] RA [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'hB, 4'hC,
        4'hD, 4'hF};
    localparam logic [15:0] RV [11] = '{16'h0017, 16'h0000, 16'h0000, 16'h0000, 16'h0001,
        16'h0000, 16'h00FF, 16'h0000, 16'h0000, 16'h0100, 16'h0000};
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    ucp_bus_t bus_q;
    logic [15:0] rdata_o, rd, d, r;
    logic irq_o, tx_o, tx_oe, rx_o, rx_oe, peer_rx, tx_w, rx_w;
    logic [1:0] stp, len;
    int bad_count, checks;
    logic [15:0] seed = 16'h8209;
    always #2 sys_clk_i = ~sys_clk_i;
    assign tx_w = tx_oe ? tx_o : 1'b1;
    assign rx_w = rx_oe ? rx_o : peer_rx;
    ucp_top uut (.sys_clk_i, .sys_rst_i, .bus_i(bus_q), .rdata_o, .irq_o,
        .serial_tx_pin_o(tx_o), .serial_tx_pin_oe_o(tx_oe), .serial_rx_pin_i(rx_w),
        .serial_rx_pin_o(rx_o), .serial_rx_pin_oe_o(rx_oe));
    ucp_peer peer (.sys_clk_i, .line_i(tx_w), .line_o(peer_rx));
    function automatic logic [15:0] rnd();
        seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
        return seed;
    endfunction
    function automatic logic [15:0] frame(input logic [8:0] dt, input logic [1:0] ln,
            input logic [1:0] par, input logic lsb, input logic [1:0] sb, output int n);
        int w;
        logic p;
        logic [15:0] f;
        w = ln == 2'h1 ? 9 : ln == 2'h2 ? 7 : 8;
        f = 16'h0000;
        for (int i = 0; i < w; i++)
            f[i + 1] = lsb ? dt[i] : dt[w - 1 - i];
        n = w + 1;
        p = ^(dt & 9'((1 << w) - 1));
        if (par != 2'h0) begin
            f[n] = par == 2'h1 ? 1'b0 : (par == 2'h3) ^ p;
            n++;
        end
        for (int i = 0; i < sb; i++)
            f[n + i] = 1'b1;
        n = n + sb;
        return f;
    endfunction
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] wd);
        @(posedge sys_clk_i);
        bus_q <= '{addr: a, wdata: wd, we: 1'b1, re: 1'b0};
        @(posedge sys_clk_i);
        bus_q.we <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a);
        @(posedge sys_clk_i);
        bus_q <= '{addr: a, wdata: 16'h0000, we: 1'b0, re: 1'b1};
        @(posedge sys_clk_i);
        bus_q.re <= 1'b0;
        #1 rd = rdata_o;
    endtask
    task automatic wait_sts(input int b);
        rd = 16'h0000;
        for (int k = 0; k < 300 && rd[b] !== 1'b1; k++)
            rdr(`UCP_OFS_STS);
    endtask
    task automatic tx_case(input logic [1:0] par, input logic inv, input logic gate);
        logic [15:0] exp, got, dv;
        int n;
        dv = rnd() | 16'h0200;
        d = rnd();
        exp = frame(d[8:0], len, par, d[12], stp, n);
        wr(`UCP_OFS_DIV, {5'h00, dv[10:9], 9'h000});
        wr(`UCP_OFS_INV, {15'h0000, inv});
        wr(`UCP_OFS_LEVEL, {15'h0000, ~inv});
        wr(`UCP_OFS_GATE, {15'h0000, gate});
        wr(`UCP_OFS_CFG, {5'h18, 1'b1, par, d[12], 1'b0, stp, 2'b01, len});
        fork
            if (gate) peer.recv(~inv, n, 2 * (dv[10:9] + 1), got);
            wr(`UCP_OFS_TXDATA, {7'h00, d[8:0]});
        join
        if (gate)
            check((got ^ {16{inv}}) & 16'((32'h1 << n) - 1), exp);
        wait_sts(`UCP_STS_TX);
        check(16'(irq_o), 16'h0001);
        wr(`UCP_OFS_MASK, 16'h0000);
        rdr(`UCP_OFS_STS);
        check(16'(irq_o), 16'h0000);
        wr(`UCP_OFS_MASK, 16'h0007);
        wr(`UCP_OFS_STS, 16'h0007);
        rdr(`UCP_OFS_STS);
        check(16'({irq_o, rd[2:0]}), 16'h0000);
    endtask
    task automatic rx_case(input logic [1:0] par, input logic [1:0] flt, input logic eoc,
            input logic filt);
        logic [15:0] fr;
        logic [8:0] dm;
        logic pe, fe;
        int n;
        d = rnd();
        fr = frame(d[8:0], len, par, d[12], stp, n);
        dm = len == 2'h1 ? 9'h1FF : len == 2'h2 ? 9'h07F : 9'h0FF;
        pe = flt == 2'h1 && par[1];
        fe = flt == 2'h2;
        if (flt == 2'h1)
            fr[n - 1 - stp] = ~fr[n - 1 - stp];
        if (fe)
            fr[n - 1] = 1'b0;
        wr(`UCP_OFS_DIV, {5'h00, d[14:13] | 2'b01, 9'h000});
        wr(`UCP_OFS_FILT, {15'h0000, filt});
        wr(`UCP_OFS_CFG, {5'h18, eoc, par, d[12], 1'b0, stp, 2'b01, len});
        repeat (4) @(posedge sys_clk_i);
        wr(`UCP_OFS_START, 16'h0002);
        peer.send(fr, n, 2 * ((d[14:13] | 2'b01) + 1));
        wait_sts(`UCP_STS_RX);
        rdr(`UCP_OFS_RXDATA);
        check(rd & 16'h31FF, {2'b00, fe, pe, 3'b000, d[8:0] & dm});
        rdr(`UCP_OFS_STS);
        check(16'(rd[2:0]), 16'({eoc & (pe | fe), 2'b10}));
        wr(`UCP_OFS_STS, 16'h0007);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge sys_clk_i);
        bad_count++;
        report_and_stop();
    end
    initial begin
        bus_q = '0;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            rdr(RA[i]);
            check(rd, RV[i]);
        end
        wr(`UCP_OFS_PDATA, 16'h0010);
        wr(`UCP_OFS_PDIR, 16'h00EF);
        wr(`UCP_OFS_MASK, 16'h0007);
        d = rnd();
        wr(`UCP_OFS_DIV, d);
        rdr(`UCP_OFS_DIV);
        check(16'(rd[15:9]), 16'(d[15:9]));
        check(16'({tx_oe, rx_oe, tx_w}), 16'h0005);
        $display("register test done");
        for (int p = 0; p < 4; p++) begin
            stp = 2'(p % 3);
            len = 2'(3 - p % 3);
            tx_case(2'(p), p[0], 1'b1);
            stp = 2'h2;
            rx_case(2'(p), p == 0 ? 2'h2 : 2'h1, p[0], p[1]);
        end
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            stp = 2'(r[3:2] % 3);
            len = 2'(1 + r[5:4] % 3);
            tx_case(r[1:0], r[6], 1'b1);
            rx_case(r[1:0], {1'b0, r[8] && r[1:0] != 2'h0}, r[9], r[10]);
        end
        $display("frame tests done");
        tx_case(2'h2, 1'b0, 1'b0);
        wr(`UCP_OFS_CFG, 16'h4017);
        wr(`UCP_OFS_TXDATA, 16'h00A5);
        rdr(`UCP_OFS_TXDATA);
        check(16'(rd[0]), 16'h0000);
        repeat (60) @(posedge sys_clk_i);
        rdr(`UCP_OFS_STS);
        check(16'(rd[0]), 16'h0000);
        $display("gate and enable tests done");
        report_and_stop();
    end
endmodule

// ===== tb/ucp_top_asserts.sv
// Port checker of the channel pair, bound to ucp_top.
// Assumes one clock and an asynchronous active-high reset.
`include "ucp_params.svh"
module ucp_top_asserts (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire ucp_pkg::ucp_bus_t bus_i,
    input wire logic [`UCP_DW-1:0] rdata_o,
    input wire logic irq_o,
    input wire logic serial_tx_pin_o,
    input wire logic serial_tx_pin_oe_o,
    input wire logic serial_rx_pin_i,
    input wire logic serial_rx_pin_o,
    input wire logic serial_rx_pin_oe_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import ucp_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    logic txe_q, gate_q, runok_q, pdir_wr;
    logic [2:0] mask_q, wr_q;
    logic [6:0] div_q;
    logic [9:0] run_q;
    assign pdir_wr = bus_i.we && bus_i.addr == `UCP_OFS_PDIR;
    // Writes move the line on purpose; runs spanning a write are not judged.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            {txe_q, gate_q, mask_q, div_q, wr_q, run_q, runok_q} <= '0;
        end else begin
            wr_q <= {wr_q[1:0], bus_i.we};
            run_q <= $changed(serial_tx_pin_o) ? 10'h001 : run_q + {9'h000, ~&run_q};
            runok_q <= ($changed(serial_tx_pin_o) || runok_q) && !bus_i.we;
            if (bus_i.we && bus_i.addr == `UCP_OFS_CFG)
                txe_q <= bus_i.wdata[`UCP_CFG_TXE];
            if (bus_i.we && bus_i.addr == `UCP_OFS_GATE)
                gate_q <= bus_i.wdata[0];
            if (bus_i.we && bus_i.addr == `UCP_OFS_MASK)
                mask_q <= bus_i.wdata[2:0];
            if (bus_i.we && bus_i.addr == `UCP_OFS_DIV)
                div_q <= bus_i.wdata[15:9];
        end
    end
    property p_rdata_idle;
        !$past(bus_i.re) |-> rdata_o == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_div_rb;
        bus_i.re && bus_i.addr == `UCP_OFS_DIV |=> rdata_o[15:9] == $past(div_q);
    endproperty
    a_div_rb: assert property (p_div_rb) else $error("divider readback wrong");
    property p_tx_dir;
        pdir_wr ##1 !pdir_wr |-> ##1 serial_tx_pin_oe_o == !$past(bus_i.wdata[4], 2);
    endproperty
    a_tx_dir: assert property (p_tx_dir) else $error("transmit pin enable wrong");
    property p_rx_dir;
        pdir_wr ##1 !pdir_wr |-> ##1 serial_rx_pin_oe_o == !$past(bus_i.wdata[5], 2);
    endproperty
    a_rx_dir: assert property (p_rx_dir) else $error("receive pin enable wrong");
    property p_gate_hold;
        !gate_q && wr_q == 3'h0 && !bus_i.we |-> $stable(serial_tx_pin_o);
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("line moved while gated");
    property p_txe_off;
        !txe_q && wr_q == 3'h0 && !bus_i.we |-> $stable(serial_tx_pin_o);
    endproperty
    a_txe_off: assert property (p_txe_off) else $error("line moved while disabled");
    property p_irq_masked;
        (mask_q == 3'h0) [*3] |-> !irq_o;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("interrupt while masked");
    property p_bit_run;
        $changed(serial_tx_pin_o) && runok_q |-> run_q >= {2'b00, div_q, 1'b0} + 10'h002;
    endproperty
    a_bit_run: assert property (p_bit_run) else $error("bit shorter than divider");
endmodule
bind ucp_top ucp_top_asserts u_asserts (.sys_clk_i, .sys_rst_i, .bus_i, .rdata_o, .irq_o,
    .serial_tx_pin_o, .serial_tx_pin_oe_o, .serial_rx_pin_i, .serial_rx_pin_o,
    .serial_rx_pin_oe_o);
